// File: btbc_regs.svh
// Constants for the bit-test branch and call execution block.
// Overview of operation
// - Operand nibble top bit is the polarity, low three bits the tested bit number.
// - General bit-test branch is taken only when the source bit equals the polarity.
// - Jump-if-set form carries a one in the nibble top bit, bit 0 to 7 below.
// - Jump-if-set adds the displacement only when the selected bit is one.
// - Jump-if-clear form carries a zero in the nibble top bit.
// - Jump-if-clear adds the displacement only when the selected bit is zero.
// - Displacement is a two's-complement byte spanning -128 to +127.
// - Exactly one bit is tested, from a working register or the register it names.
// - Displacement is added to the address past the branch; untaken falls through.
// - Branches and calls leave all arithmetic and status flags unchanged.
// - A call first lowers the stack pointer by two.
// - The call then stores the next instruction address at the new stack top.
// - The call finally loads the program counter with the target address.
// - Direct call opcode is followed by the target, high byte then low byte.
// - Indirect call names a register pair whose 16-bit contents are the target.
// - The return pops the stack top word into the program counter.
// - Register operand with upper nibble 1110 names a working register.
`ifndef BTBC_REGS_SVH
`define BTBC_REGS_SVH
`define BTBC_OP_BTJ_DIR   8'hF6
`define BTBC_OP_BTJ_IND   8'hF7
`define BTBC_OP_CALL_IND  8'hD4
`define BTBC_OP_CALL_DIR  8'hD6
`define BTBC_OP_RET       8'hAF
`define BTBC_ESC_NIB      4'hE
`define BTBC_POL_BIT      7
`define BTBC_BIT_HI       6
`define BTBC_BIT_LO       4
`define BTBC_SP_STEP      16'h0002
`define BTBC_ONE          16'h0001
`define BTBC_LEN_BTJ      16'h0003
`define BTBC_LEN_CALL_D   16'h0003
`define BTBC_LEN_CALL_I   16'h0002
`define BTBC_LEN_RET      16'h0001
`define BTBC_FLAGS_RST    8'h00
`endif

// File: btbc_pkg.sv
// Package with the types of the bit-test branch and call execution block.
package btbc_pkg;
    typedef enum logic [3:0] {
        BTBC_IDLE, BTBC_SRC, BTBC_IND, BTBC_PAIR_HI, BTBC_PAIR_LO,
        BTBC_PUSH_LO, BTBC_PUSH_HI, BTBC_POP_HI, BTBC_POP_LO, BTBC_DONE
    } btbc_state_t;
endpackage : btbc_pkg

// File: btbc_addr.sv
// Register operand address resolution with working-register escape.
`timescale 1ns/1ps
`include "btbc_regs.svh"
module btbc_addr
    import btbc_pkg::*;
(
    input  wire logic [7:0]  operand,
    input  wire logic [7:0]  registerPointer,
    input  wire logic        forceWorking,
    output      logic [11:0] regAddr
);
    wire escaped = forceWorking || (operand[7:4] == `BTBC_ESC_NIB);
    assign regAddr = escaped ? {registerPointer[3:0], registerPointer[7:4], operand[3:0]}
                             : {4'h0, operand};
endmodule : btbc_addr

// File: btbc_exec.sv
// Execution unit for bit-test branches, subroutine call and return.
`timescale 1ns/1ps
`include "btbc_regs.svh"
module btbc_exec
    import btbc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [7:0]  opcode,
    input  wire logic [7:0]  operand1,
    input  wire logic [7:0]  operand2,
    input  wire logic [15:0] instrAddr,
    input  wire logic [7:0]  registerPointer,
    input  wire logic [15:0] stackPointerIn,
    input  wire logic [7:0]  flagsIn,
    input  wire logic [7:0]  regRdData,
    input  wire logic [7:0]  stackRdData,
    output      logic [11:0] regRdAddr,
    output      logic        regRdEn,
    output      logic [15:0] stackAddr,
    output      logic [7:0]  stackWrData,
    output      logic        stackWrEn,
    output      logic        stackRdEn,
    output      logic [15:0] stackPointer,
    output      logic        stackPointerWe,
    output      logic [15:0] programCounter,
    output      logic        programCounterWe,
    output      logic [7:0]  flagsOut,
    output      logic        busy,
    output      logic        done,
    output      logic        branchTaken
);
    btbc_state_t state;
    btbc_state_t next_state;
    logic [7:0]  opc;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [15:0] pcBase;
    logic [7:0]  hiByte;
    logic [15:0] target;
    logic [15:0] spWork;

    function automatic logic [15:0] addSigned(input logic [15:0] base, input logic [7:0] disp);
        addSigned = base + {{8{disp[7]}}, disp};
    endfunction : addSigned

    wire         isBtj      = (opc == `BTBC_OP_BTJ_DIR) || (opc == `BTBC_OP_BTJ_IND);
    wire         isBtjInd   = (opc == `BTBC_OP_BTJ_IND);
    wire         isCallDir  = (opc == `BTBC_OP_CALL_DIR);
    wire         isCallInd  = (opc == `BTBC_OP_CALL_IND);
    wire         isRet      = (opc == `BTBC_OP_RET);
    wire         polarity   = op1[`BTBC_POL_BIT];
    wire [2:0]   bitSel     = op1[`BTBC_BIT_HI:`BTBC_BIT_LO];
    wire         srcBit     = regRdData[bitSel];
    wire         bitMatch   = (srcBit == polarity);
    wire [15:0]  branchDest = addSigned(pcBase, op2);
    wire [15:0]  spDown     = stackPointerIn - `BTBC_SP_STEP;
    wire [11:0]  srcRegAddr;
    wire [11:0]  pairRegAddr;
    wire [11:0]  indRegAddr = {4'h0, regRdData};
    wire [11:0]  pairLoAddr = pairRegAddr + 12'h001;
    wire [7:0]   pairOperand = (state == BTBC_IDLE) ? operand1 : op1;
    wire [7:0]   newOpc     = opcode;
    wire [15:0]  newLen     = (opcode == `BTBC_OP_RET)      ? `BTBC_LEN_RET :
                              (opcode == `BTBC_OP_CALL_IND) ? `BTBC_LEN_CALL_I :
                              (opcode == `BTBC_OP_CALL_DIR) ? `BTBC_LEN_CALL_D :
                                                              `BTBC_LEN_BTJ;
    wire [15:0]  nextAddr   = instrAddr + newLen;

    btbc_addr u_src (
        .operand         (op1),
        .registerPointer (registerPointer),
        .forceWorking    (1'b1),
        .regAddr         (srcRegAddr)
    );

    btbc_addr u_pair (
        .operand         (pairOperand),
        .registerPointer (registerPointer),
        .forceWorking    (1'b0),
        .regAddr         (pairRegAddr)
    );

    always_comb begin
        next_state = state;
        case (state)
            BTBC_IDLE: begin
                if (start) begin
                    if ((newOpc == `BTBC_OP_BTJ_DIR) || (newOpc == `BTBC_OP_BTJ_IND)) begin
                        next_state = BTBC_SRC;
                    end else if (newOpc == `BTBC_OP_CALL_IND) begin
                        next_state = BTBC_PAIR_HI;
                    end else if (newOpc == `BTBC_OP_CALL_DIR) begin
                        next_state = BTBC_PUSH_LO;
                    end else if (newOpc == `BTBC_OP_RET) begin
                        next_state = BTBC_POP_HI;
                    end else begin
                        next_state = BTBC_DONE;
                    end
                end
            end
            BTBC_SRC:     next_state = isBtjInd ? BTBC_IND : BTBC_DONE;
            BTBC_IND:     next_state = BTBC_DONE;
            BTBC_PAIR_HI: next_state = BTBC_PAIR_LO;
            BTBC_PAIR_LO: next_state = BTBC_PUSH_LO;
            BTBC_PUSH_LO: next_state = BTBC_PUSH_HI;
            BTBC_PUSH_HI: next_state = BTBC_DONE;
            BTBC_POP_HI:  next_state = BTBC_POP_LO;
            BTBC_POP_LO:  next_state = BTBC_DONE;
            BTBC_DONE:    next_state = BTBC_IDLE;
            default:      next_state = BTBC_IDLE;
        endcase
    end

    // Latching the instruction and its operands on start.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state  <= BTBC_IDLE;
            opc    <= 8'h00;
            op1    <= 8'h00;
            op2    <= 8'h00;
            pcBase <= 16'h0000;
        end else begin
            state <= next_state;
            if (state == BTBC_IDLE && start) begin
                opc    <= opcode;
                op1    <= operand1;
                op2    <= operand2;
                pcBase <= instrAddr + newLen;
            end
        end
    end

    // Register file read port.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            regRdAddr <= 12'h000;
            regRdEn   <= 1'b0;
        end else begin
            regRdEn <= (next_state == BTBC_SRC) || (next_state == BTBC_IND) ||
                       (next_state == BTBC_PAIR_HI) || (next_state == BTBC_PAIR_LO);
            case (next_state)
                BTBC_SRC:     regRdAddr <= {registerPointer[3:0], registerPointer[7:4],
                                            operand1[3:0]};
                BTBC_IND:     regRdAddr <= indRegAddr;
                BTBC_PAIR_HI: regRdAddr <= pairRegAddr;
                BTBC_PAIR_LO: regRdAddr <= pairLoAddr;
                default:      regRdAddr <= srcRegAddr;
            endcase
        end
    end

    // Call target capture.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hiByte <= 8'h00;
            target <= 16'h0000;
        end else begin
            if (state == BTBC_IDLE && start) begin
                target <= {operand1, operand2};
            end else if (state == BTBC_PAIR_HI) begin
                hiByte <= regRdData;
            end else if (state == BTBC_PAIR_LO && isCallInd) begin
                target <= {hiByte, regRdData};
            end else if (state == BTBC_POP_HI) begin
                hiByte <= stackRdData;
            end
        end
    end

    // Stack traffic.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            stackAddr      <= 16'h0000;
            stackWrData    <= 8'h00;
            stackWrEn      <= 1'b0;
            stackRdEn      <= 1'b0;
            stackPointer   <= 16'h0000;
            stackPointerWe <= 1'b0;
            spWork         <= 16'h0000;
        end else begin
            stackWrEn      <= 1'b0;
            stackRdEn      <= 1'b0;
            stackPointerWe <= 1'b0;
            if (next_state == BTBC_PUSH_LO) begin
                spWork         <= spDown;
                stackPointer   <= spDown;
                stackPointerWe <= 1'b1;
                stackAddr      <= spDown + `BTBC_ONE;
                stackWrData    <= (state == BTBC_IDLE) ? nextAddr[7:0] : pcBase[7:0];
                stackWrEn      <= 1'b1;
            end else if (next_state == BTBC_PUSH_HI) begin
                stackAddr   <= spWork;
                stackWrData <= pcBase[15:8];
                stackWrEn   <= 1'b1;
            end else if (next_state == BTBC_POP_HI) begin
                stackAddr <= stackPointerIn;
                stackRdEn <= 1'b1;
                spWork    <= stackPointerIn;
            end else if (next_state == BTBC_POP_LO) begin
                stackAddr <= spWork + `BTBC_ONE;
                stackRdEn <= 1'b1;
            end else if (state == BTBC_POP_LO) begin
                stackPointer   <= spWork + `BTBC_SP_STEP;
                stackPointerWe <= 1'b1;
            end
        end
    end

    // Program counter update and completion.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            programCounter   <= 16'h0000;
            programCounterWe <= 1'b0;
            branchTaken      <= 1'b0;
            done             <= 1'b0;
            busy             <= 1'b0;
            flagsOut         <= `BTBC_FLAGS_RST;
        end else begin
            programCounterWe <= 1'b0;
            branchTaken      <= 1'b0;
            done             <= (state == BTBC_DONE);
            busy             <= (next_state != BTBC_IDLE);
            flagsOut         <= flagsIn;
            if (isBtj && ((state == BTBC_SRC && !isBtjInd) || state == BTBC_IND)) begin
                programCounter   <= bitMatch ? branchDest : pcBase;
                programCounterWe <= 1'b1;
                branchTaken      <= bitMatch;
            end else if (state == BTBC_PUSH_HI) begin
                programCounter   <= target;
                programCounterWe <= 1'b1;
            end else if (state == BTBC_POP_LO) begin
                programCounter   <= {hiByte, stackRdData};
                programCounterWe <= 1'b1;
            end else if (state == BTBC_IDLE && start && !((opcode == `BTBC_OP_BTJ_DIR) ||
                         (opcode == `BTBC_OP_BTJ_IND) || (opcode == `BTBC_OP_CALL_IND) ||
                         (opcode == `BTBC_OP_CALL_DIR) || (opcode == `BTBC_OP_RET))) begin
                programCounter   <= instrAddr + `BTBC_ONE;
                programCounterWe <= 1'b1;
            end
        end
    end
endmodule : btbc_exec

// File: btbc_exec_properties.sv
// Concurrent checks on the bit-test branch and call execution unit.
`timescale 1ns/1ps
module btbc_exec_properties
    import btbc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        start,
    input wire logic        busy,
    input wire logic [7:0]  opcode,
    input wire logic [7:0]  operand1,
    input wire logic [7:0]  operand2,
    input wire logic [15:0] instrAddr,
    input wire logic [7:0]  registerPointer,
    input wire logic [15:0] stackPointerIn,
    input wire logic [7:0]  flagsIn,
    input wire logic [7:0]  flagsOut,
    input wire logic [7:0]  regRdData,
    input wire logic [11:0] regRdAddr,
    input wire logic        regRdEn,
    input wire logic [15:0] stackAddr,
    input wire logic [7:0]  stackWrData,
    input wire logic        stackWrEn,
    input wire logic [15:0] stackPointer,
    input wire logic        stackPointerWe,
    input wire logic [15:0] programCounter,
    input wire logic        programCounterWe,
    input wire logic        done,
    input wire logic        branchTaken
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire        goBt = start && !busy && opcode == 8'hF6;
    wire        goCd = start && !busy && opcode == 8'hD6;
    wire [15:0] nxt  = instrAddr + 16'h0003;
    wire [15:0] disp = {{8{operand2[7]}}, operand2};
    flags_kept_a: assert property (!$past(rst) |-> flagsOut == $past(flagsIn))
        else $error("flags output changed");
    src_addr_a: assert property (goBt |=> regRdEn &&
        regRdAddr == {registerPointer[3:0], registerPointer[7:4], operand1[3:0]})
        else $error("bit source address wrong");
    bt_branch_a: assert property (goBt |=> ##1 programCounterWe &&
        branchTaken == ($past(regRdData[operand1[6:4]]) == operand1[7]) &&
        programCounter == nxt + (branchTaken ? disp : 16'h0000))
        else $error("bit test branch result wrong");
    done_follows_a: assert property (programCounterWe |=> done && !programCounterWe)
        else $error("done not after program counter write");
    push_low_a: assert property (goCd |=> stackPointerWe &&
        stackPointer == stackPointerIn - 16'h0002 && stackWrEn &&
        stackAddr == stackPointerIn - 16'h0001 && stackWrData == nxt[7:0])
        else $error("call low push wrong");
    push_high_a: assert property (goCd |=> ##1 stackWrEn &&
        stackAddr == stackPointerIn - 16'h0002 && stackWrData == nxt[15:8])
        else $error("call high push wrong");
    call_target_a: assert property (goCd |=> ##2 programCounterWe &&
        programCounter == {operand1, operand2})
        else $error("call target wrong");
    ret_load_a: assert property (start && !busy && opcode == 8'hAF |=> ##2 programCounterWe)
        else $error("return program counter write late");
endmodule : btbc_exec_properties

bind btbc_exec btbc_exec_properties u_props (.*);

// File: test_bit_test_branch_and_call_exec.sv
// Self-checking testbench for the bit-test branch and call execution unit.
`timescale 1ns/1ps
module test_bit_test_branch_and_call_exec
    import btbc_pkg::*;
;
    logic        core_clk = 1'b0, rst = 1'b1, start = 1'b0, gotBt;
    logic [7:0]  opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
    logic [7:0]  registerPointer = 8'h20, flagsIn = 8'hA5;
    logic [15:0] instrAddr = 16'h0000, stackPointerIn = 16'h0000, gotPc, gotSp;
    logic [7:0]  regRdData, stackRdData, stackWrData, flagsOut;
    logic [11:0] regRdAddr;
    logic [15:0] stackAddr, stackPointer, programCounter;
    logic        regRdEn, stackWrEn, stackRdEn, stackPointerWe, programCounterWe, busy, done;
    logic        branchTaken;
    logic [7:0]  rf [0:4095];
    logic [7:0]  sm [0:65535];
    int          error_cnt = 0, n_compared = 0;
    always #4 core_clk = ~core_clk;
    assign regRdData   = rf[regRdAddr];
    assign stackRdData = sm[stackAddr];
    always @(posedge core_clk) if (stackWrEn) sm[stackAddr] <= stackWrData;
    btbc_exec u_dut (.*);
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic run(input logic [7:0] op, o1, o2, input logic [15:0] ia, sp);
        @(posedge core_clk);
        opcode         <= op;
        operand1       <= o1;
        operand2       <= o2;
        instrAddr      <= ia;
        stackPointerIn <= sp;
        start          <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        gotBt = 1'b0;
        for (int i = 0; i < 20 && done !== 1'b1; i++) begin
            @(negedge core_clk);
            if (programCounterWe === 1'b1) begin
                gotPc = programCounter;
                gotBt = branchTaken;
            end
            if (stackPointerWe === 1'b1) gotSp = stackPointer;
        end
        chk("done", 16'h0001, {15'h0000, done});
        chk("flags", {8'h00, flagsIn}, {8'h00, flagsOut});
    endtask : run
    task automatic t_bits();
        logic tk;
        rf[12'h027] = 8'h20;
        for (int n = 0; n < 16; n++) begin
            run(8'hF6, {n[3:0], 4'h7}, n[0] ? 8'h80 : 8'h7F, 16'h1000, 16'h3002);
            tk = ((n[2:0] == 3'd5) == n[3]);
            chk("taken", {15'h0000, tk}, {15'h0000, gotBt});
            chk("pc", 16'h1003 + (tk ? (n[0] ? 16'hFF80 : 16'h007F) : 16'h0000), gotPc);
        end
        $display("test bit codes done");
    endtask : t_bits
    task automatic t_ind();
        rf[12'h023] = 8'h3E;
        rf[12'h03E] = 8'h04;
        run(8'hF7, 8'hA3, 8'hFE, 16'h2000, 16'h3002);
        chk("ind set pc", 16'h2001, gotPc);
        run(8'hF7, 8'h23, 8'hFE, 16'h2000, 16'h3002);
        chk("ind clear pc", 16'h2003, gotPc);
        rf[12'h026] = 8'hE5;
        rf[12'h0E5] = 8'h01;
        run(8'hF7, 8'h86, 8'h10, 16'h2000, 16'h3002);
        chk("ind high page pc", 16'h2013, gotPc);
        $display("test indirect source done");
    endtask : t_ind
    task automatic t_call();
        run(8'hD6, 8'h35, 8'h21, 16'h1A47, 16'h3002);
        chk("sp", 16'h3000, gotSp);
        chk("push", 16'h1A4A, {sm[16'h3000], sm[16'h3001]});
        chk("call pc", 16'h3521, gotPc);
        run(8'hAF, 8'h00, 8'h00, 16'h3521, gotSp);
        chk("ret pc", 16'h1A4A, gotPc);
        chk("ret sp", 16'h3002, gotSp);
        rf[12'h024] = 8'h35;
        rf[12'h025] = 8'h21;
        rf[12'h0A4] = 8'h12;
        rf[12'h0A5] = 8'h34;
        run(8'hD4, 8'hE4, 8'h00, 16'h1A47, 16'h3724);
        chk("ind call pc", 16'h3521, gotPc);
        chk("ind push", 16'h1A49, {sm[16'h3722], sm[16'h3723]});
        run(8'hD4, 8'hA4, 8'h00, 16'h1A47, 16'h3724);
        chk("pair call pc", 16'h1234, gotPc);
        run(8'h00, 8'h00, 8'h00, 16'h4000, 16'h3002);
        chk("other opcode pc", 16'h4001, gotPc);
        $display("test call and return done");
    endtask : t_call
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        t_bits();
        t_ind();
        t_call();
        print_verdict();
    end
    initial begin
        repeat (2000) @(posedge core_clk);
        error_cnt++;
        print_verdict();
    end
endmodule : test_bit_test_branch_and_call_exec
